// ==== inc/tmc_cfg.svh ====
// Constants of the byte-access 16-bit timer core
// Functional notes
// - Counter, compares, capture: 16 bits, two bytes
// - One shared high-byte holding register
// - Low-byte write loads holding plus low together
// - Counter or capture low-byte read copies upper byte to holding
// - Compare reads bypass holding, leave it unchanged
// - Holding register kept across low-byte writes
// - Clock select field picks tick source
// - Up/down counter with clear, top, bottom
// - Bottom at zero, top at sequence maximum
// - Upper-byte counter location reaches holding register
// - Counter steps only on timer tick
// - Clock select zero stops the counter
// - CPU reaches counter at any time
// - CPU write beats clear or count
// - Waveform mode split across control A, B
// - Overflow flag set per waveform mode
// - Top from fixed constants, compare A, capture
// - Maximum 0xFFFF, bottom 0x0000
`ifndef TMC_CFG_SVH
`define TMC_CFG_SVH
`define TMC_A_CNT_LO 4'h0
`define TMC_A_CNT_HI 4'h1
`define TMC_A_CMPA_LO 4'h2
`define TMC_A_CMPA_HI 4'h3
`define TMC_A_CMPB_LO 4'h4
`define TMC_A_CMPB_HI 4'h5
`define TMC_A_CAP_LO 4'h6
`define TMC_A_CAP_HI 4'h7
`define TMC_A_CTRL_A 4'h8
`define TMC_A_CTRL_B 4'h9
`define TMC_A_FLAG 4'hA
`define TMC_MAX 16'hFFFF
`define TMC_BOTTOM 16'h0000
`define TMC_TOP8 16'h00FF
`define TMC_TOP9 16'h01FF
`define TMC_TOP10 16'h03FF
`define TMC_ZERO8 8'h00
`define TMC_ONE16 16'h0001
`define TMC_CS_LSB 0
`define TMC_CS_MSB 2
`define TMC_WGM_LO_LSB 0
`define TMC_WGM_LO_MSB 1
`define TMC_WGM_HI_LSB 3
`define TMC_WGM_HI_MSB 4
`define TMC_OVF_BIT 0
`define TMC_CS_STOP 3'h0
`define TMC_CS_DIV1 3'h1
`define TMC_CS_DIV8 3'h2
`define TMC_CS_DIV64 3'h3
`define TMC_CS_DIV256 3'h4
`define TMC_CS_DIV1024 3'h5
`define TMC_CS_EXT_FALL 3'h6
`define TMC_CS_EXT_RISE 3'h7
`define TMC_PS_M8 10'h007
`define TMC_PS_M64 10'h03F
`define TMC_PS_M256 10'h0FF
`define TMC_PS_M1024 10'h3FF
`define TMC_PS_ONE 10'h001
`define TMC_PS_ZERO 10'h000
`endif

// ==== inc/tmc_pkg.sv ====
// Types of the byte-access 16-bit timer core
package tmc_pkg;
  typedef enum logic [1:0] {TMC_SRC_FIXED, TMC_SRC_CMPA, TMC_SRC_CAP} tmc_top_src_e;
  typedef enum logic [1:0] {TMC_SEQ_NORMAL, TMC_SEQ_CTC, TMC_SEQ_FAST, TMC_SEQ_DUAL} tmc_seq_e;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tmc_bus_req_s;
  typedef struct packed {
    logic [15:0] count;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [15:0] cap;
    logic [3:0] wave_mode;
    logic count_down;
    logic overflow_flag;
  } tmc_view_s;
  typedef struct packed {
    logic [15:0] cnt;
    logic [7:0] hold;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [15:0] cap;
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic ovf;
    logic down;
    logic [9:0] presc;
    logic ext_prev;
    logic [7:0] rdata;
  } tmc_state_s;
endpackage : tmc_pkg

// ==== logic/tmc_core.sv ====
// Byte-access 16-bit timer/counter core
`timescale 1ns/1ps
`default_nettype none
`include "tmc_cfg.svh"

module tmc_core (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Byte register port
  input wire tmc_pkg::tmc_bus_req_s bus_req,
  output logic [7:0] rd_data,
  // Tick and capture sources, overflow acknowledge
  input wire logic ext_tick_pin,
  input wire logic capture_event,
  input wire logic ovf_ack,
  // Timer view
  output tmc_pkg::tmc_view_s view,
  output logic timer_tick,
  output logic count_top,
  output logic count_bottom
);
  import tmc_pkg::*;

  tmc_state_s s_q;
  tmc_state_s s_d;

  logic [2:0] clock_select_field;
  logic [3:0] waveform_mode_field;
  tmc_seq_e seq;
  tmc_top_src_e top_src;
  logic [15:0] top_fixed;
  logic [15:0] top_val;
  logic presc_hit;
  logic ext_edge;
  logic at_top;
  logic at_bottom;
  logic ovf_set;
  logic cnt_wr;
  logic [15:0] cnt_step;
  logic down_step;
  logic past_top;
  logic ovf_clr;

  // Sequence shape of each waveform mode
  function automatic tmc_seq_e seq_of(input logic [3:0] m);
    case (m)
      4'h0, 4'hD: seq_of = TMC_SEQ_NORMAL;
      4'h4, 4'hC: seq_of = TMC_SEQ_CTC;
      4'h5, 4'h6, 4'h7, 4'hE, 4'hF: seq_of = TMC_SEQ_FAST;
      default: seq_of = TMC_SEQ_DUAL;
    endcase
  endfunction

  // Where the top value comes from in each mode
  function automatic tmc_top_src_e src_of(input logic [3:0] m);
    case (m)
      4'h4, 4'h9, 4'hB, 4'hF: src_of = TMC_SRC_CMPA;
      4'h8, 4'hA, 4'hC, 4'hE: src_of = TMC_SRC_CAP;
      default: src_of = TMC_SRC_FIXED;
    endcase
  endfunction

  // Fixed top for the 8, 9 and 10 bit modes
  function automatic logic [15:0] fixed_of(input logic [3:0] m);
    case (m)
      4'h1, 4'h5: fixed_of = `TMC_TOP8;
      4'h2, 4'h6: fixed_of = `TMC_TOP9;
      4'h3, 4'h7: fixed_of = `TMC_TOP10;
      default: fixed_of = `TMC_MAX;
    endcase
  endfunction

  // One write strobe aimed at one byte location
  function automatic logic wr_hit(input tmc_bus_req_s r, input logic [3:0] loc);
    wr_hit = r.wr && r.addr == loc;
  endfunction

  // Mode bits live in both control registers
  assign waveform_mode_field = {s_q.ctrl_b[`TMC_WGM_HI_MSB:`TMC_WGM_HI_LSB],
                                s_q.ctrl_a[`TMC_WGM_LO_MSB:`TMC_WGM_LO_LSB]};
  assign clock_select_field = s_q.ctrl_b[`TMC_CS_MSB:`TMC_CS_LSB];
  assign seq = seq_of(waveform_mode_field);
  assign top_src = src_of(waveform_mode_field);
  assign top_fixed = fixed_of(waveform_mode_field);

  always_comb begin
    case (top_src)
      TMC_SRC_CMPA: top_val = s_q.cmp_a;
      TMC_SRC_CAP: top_val = s_q.cap;
      TMC_SRC_FIXED: top_val = top_fixed;
      default: top_val = top_fixed;
    endcase
  end

  // Prescaler runs except while stopped; taps are the all-ones points of each ratio
  always_comb begin
    case (clock_select_field)
      `TMC_CS_DIV8: presc_hit = (s_q.presc & `TMC_PS_M8) == `TMC_PS_M8;
      `TMC_CS_DIV64: presc_hit = (s_q.presc & `TMC_PS_M64) == `TMC_PS_M64;
      `TMC_CS_DIV256: presc_hit = (s_q.presc & `TMC_PS_M256) == `TMC_PS_M256;
      `TMC_CS_DIV1024: presc_hit = s_q.presc == `TMC_PS_M1024;
      default: presc_hit = 1'b0;
    endcase
  end

  // External pin is taken as already synchronous
  always_comb begin
    case (clock_select_field)
      `TMC_CS_EXT_FALL: ext_edge = s_q.ext_prev & ~ext_tick_pin;
      `TMC_CS_EXT_RISE: ext_edge = ~s_q.ext_prev & ext_tick_pin;
      default: ext_edge = 1'b0;
    endcase
  end

  always_comb begin
    case (clock_select_field)
      `TMC_CS_STOP: timer_tick = 1'b0;
      `TMC_CS_DIV1: timer_tick = 1'b1;
      `TMC_CS_EXT_FALL, `TMC_CS_EXT_RISE: timer_tick = ext_edge;
      default: timer_tick = presc_hit;
    endcase
  end

  // Top in normal mode is the counter maximum
  assign at_top = (seq == TMC_SEQ_NORMAL) ? (s_q.cnt == `TMC_MAX) : (s_q.cnt == top_val);
  assign at_bottom = s_q.cnt == `TMC_BOTTOM;
  // A top lowered under the count turns the dual slope at once
  assign past_top = s_q.cnt > top_val;
  // Indications leave unregistered for the waveform side
  assign count_top = at_top;
  assign count_bottom = at_bottom;

  // Next count and direction for one tick
  always_comb begin
    cnt_step = s_q.cnt + `TMC_ONE16;
    down_step = 1'b0;
    ovf_set = 1'b0;
    case (seq)
      TMC_SEQ_NORMAL: begin
        ovf_set = s_q.cnt == `TMC_MAX;
      end
      TMC_SEQ_CTC: begin
        if (at_top) begin
          cnt_step = `TMC_BOTTOM;
        end
        ovf_set = s_q.cnt == `TMC_MAX;
      end
      TMC_SEQ_FAST: begin
        if (at_top) begin
          cnt_step = `TMC_BOTTOM;
        end
        ovf_set = at_top;
      end
      TMC_SEQ_DUAL: begin
        down_step = s_q.down;
        if (!s_q.down && (at_top || past_top)) begin
          down_step = 1'b1;
        end else if (s_q.down && at_bottom) begin
          down_step = 1'b0;
          ovf_set = 1'b1;
        end
        // Past-top values after a late top change fall back down
        if (down_step) begin
          cnt_step = s_q.cnt - `TMC_ONE16;
        end
      end
      default: begin
        ovf_set = 1'b0;
      end
    endcase
  end

  assign cnt_wr = wr_hit(bus_req, `TMC_A_CNT_LO);
  // Write-one-to-clear, or the handler's acknowledge
  assign ovf_clr = (wr_hit(bus_req, `TMC_A_FLAG) && bus_req.wdata[`TMC_OVF_BIT]) || ovf_ack;

  always_comb begin
    s_d = s_q;
    s_d.ext_prev = ext_tick_pin;
    s_d.presc = s_q.presc + `TMC_PS_ONE;
    // Parked at zero while stopped, so the tick phase starts clean
    if (clock_select_field == `TMC_CS_STOP) begin
      s_d.presc = `TMC_PS_ZERO;
    end
    s_d.rdata = `TMC_ZERO8;

    // Counting only on a tick, and a write beats it
    if (timer_tick && !cnt_wr) begin
      s_d.cnt = cnt_step;
      s_d.down = down_step;
    end

    // Capture is blocked while it sets the top
    if (capture_event && top_src != TMC_SRC_CAP) begin
      s_d.cap = s_q.cnt;
    end

    // Byte writes: exactly one location per strobe
    if (bus_req.wr) begin
      case (bus_req.addr)
        `TMC_A_CNT_HI, `TMC_A_CMPA_HI, `TMC_A_CMPB_HI, `TMC_A_CAP_HI: begin
          s_d.hold = bus_req.wdata;
        end
        `TMC_A_CNT_LO: begin
          s_d.cnt = {s_q.hold, bus_req.wdata};
        end
        `TMC_A_CMPA_LO: begin
          s_d.cmp_a = {s_q.hold, bus_req.wdata};
        end
        `TMC_A_CMPB_LO: begin
          s_d.cmp_b = {s_q.hold, bus_req.wdata};
        end
        `TMC_A_CAP_LO: begin
          s_d.cap = {s_q.hold, bus_req.wdata};
        end
        `TMC_A_CTRL_A: begin
          s_d.ctrl_a = bus_req.wdata;
        end
        `TMC_A_CTRL_B: begin
          s_d.ctrl_b = bus_req.wdata;
        end
        default: begin
          s_d.hold = s_q.hold;
        end
      endcase
    end

    // Byte reads, answered in the following cycle
    if (bus_req.rd) begin
      case (bus_req.addr)
        `TMC_A_CNT_LO: begin
          s_d.rdata = s_q.cnt[7:0];
          s_d.hold = s_q.cnt[15:8];
        end
        `TMC_A_CAP_LO: begin
          s_d.rdata = s_q.cap[7:0];
          s_d.hold = s_q.cap[15:8];
        end
        `TMC_A_CNT_HI, `TMC_A_CAP_HI: begin
          s_d.rdata = s_q.hold;
        end
        `TMC_A_CMPA_LO: begin
          s_d.rdata = s_q.cmp_a[7:0];
        end
        `TMC_A_CMPA_HI: begin
          s_d.rdata = s_q.cmp_a[15:8];
        end
        `TMC_A_CMPB_LO: begin
          s_d.rdata = s_q.cmp_b[7:0];
        end
        `TMC_A_CMPB_HI: begin
          s_d.rdata = s_q.cmp_b[15:8];
        end
        `TMC_A_CTRL_A: begin
          s_d.rdata = s_q.ctrl_a;
        end
        `TMC_A_CTRL_B: begin
          s_d.rdata = s_q.ctrl_b;
        end
        `TMC_A_FLAG: begin
          s_d.rdata = `TMC_ZERO8;
          s_d.rdata[`TMC_OVF_BIT] = s_q.ovf;
        end
        default: begin
          s_d.rdata = `TMC_ZERO8;
        end
      endcase
    end

    // Flag clear by one-write or acknowledge; a same-cycle set wins
    if (ovf_clr) begin
      s_d.ovf = 1'b0;
    end
    if (timer_tick && !cnt_wr && ovf_set) begin
      s_d.ovf = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Read data is zero outside its answer cycle
  assign rd_data = s_q.rdata;

  // Timer view straight from the registers
  always_comb begin
    view.count = s_q.cnt;
    view.cmp_a = s_q.cmp_a;
    view.cmp_b = s_q.cmp_b;
    view.cap = s_q.cap;
    view.wave_mode = waveform_mode_field;
    view.count_down = s_q.down;
    view.overflow_flag = s_q.ovf;
  end

endmodule // tmc_core
`default_nettype wire

// ==== tb/tmc_cpu.sv ====
// CPU-side byte bus master model for the timer core
`timescale 1ns/1ps
`default_nettype none
module tmc_cpu (
  // Bus
  input wire logic clk,
  output var tmc_pkg::tmc_bus_req_s bus_req,
  input wire logic [7:0] rd_data
);
  import tmc_pkg::*;
  initial bus_req = '0;
  task automatic put(input logic [3:0] a, input logic [7:0] d, input logic w, input logic r);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: r};
  endtask
  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    put(a, d, 1'h1, 1'h0);
    put(4'h0, 8'h00, 1'h0, 1'h0);
  endtask
  task automatic rd8(input logic [3:0] a, output logic [7:0] d);
    put(a, 8'h00, 1'h0, 1'h1);
    put(4'h0, 8'h00, 1'h0, 1'h0);
    #1 d = rd_data;
  endtask
  // Two bytes back to back, nothing in between
  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    put(a + 4'h1, v[15:8], 1'h1, 1'h0);
    put(a, v[7:0], 1'h1, 1'h0);
    put(4'h0, 8'h00, 1'h0, 1'h0);
  endtask
  task automatic rd16(input logic [3:0] a, output logic [15:0] v);
    put(a, 8'h00, 1'h0, 1'h1);
    put(a + 4'h1, 8'h00, 1'h0, 1'h1);
    #1 v[7:0] = rd_data;
    put(4'h0, 8'h00, 1'h0, 1'h0);
    #1 v[15:8] = rd_data;
  endtask
endmodule // tmc_cpu
`default_nettype wire

// ==== tb/tmc_core_props.sv ====
// Property checker for the byte-access timer core
`timescale 1ns/1ps
`default_nettype none
module tmc_core_props (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Bus and timer view
  input wire tmc_pkg::tmc_bus_req_s bus_req,
  input wire logic [7:0] rd_data,
  input wire tmc_pkg::tmc_view_s view,
  input wire logic timer_tick,
  input wire logic count_top,
  input wire logic count_bottom
);
  import tmc_pkg::*;
  logic wr_lo;
  assign wr_lo = bus_req.wr && (bus_req.addr == 4'h0);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_bottom_seen: assert property (count_bottom == (view.count == 16'h0000))
    else $error("bottom indication wrong");
  a_top_max: assert property (view.wave_mode == 4'h0 |-> count_top == (view.count == 16'hffff))
    else $error("top indication wrong");
  a_hold_still: assert property (!timer_tick && !wr_lo |=> $stable(view.count))
    else $error("counter moved without tick");
  a_step_up: assert property (timer_tick && !wr_lo && view.wave_mode == 4'h0
    |=> view.count == $past(view.count) + 16'h0001)
    else $error("counter did not step");
  a_write_wins: assert property (bus_req.wr && bus_req.addr == 4'h1 ##1 wr_lo
    |=> view.count == {$past(bus_req.wdata, 2), $past(bus_req.wdata)})
    else $error("counter write lost");
  a_cmp_direct: assert property (bus_req.rd && bus_req.addr == 4'h5 |=> rd_data == $past(view.cmp_b[15:8]))
    else $error("compare high byte wrong");
  a_cnt_pair: assert property (bus_req.rd && bus_req.addr == 4'h0 ##1 bus_req.rd && bus_req.addr == 4'h1
    |=> rd_data == $past(view.count[15:8], 2))
    else $error("counter high byte not latched");
  a_rd_idle: assert property (!bus_req.rd |=> rd_data == 8'h00)
    else $error("read data without read");
  a_ovf_set: assert property (timer_tick && !wr_lo && view.wave_mode == 4'h0 && view.count == 16'hffff
    |=> view.overflow_flag)
    else $error("overflow flag not set");
  cover property (wr_lo && timer_tick);
  cover property (view.overflow_flag);
  cover property (count_top);
endmodule // tmc_core_props
bind tmc_core tmc_core_props u_props (.clk(clk), .resetn(resetn), .bus_req(bus_req), .rd_data(rd_data),
  .view(view), .timer_tick(timer_tick), .count_top(count_top), .count_bottom(count_bottom));
`default_nettype wire

// ==== tb/timer16_counter_byte_access_tb_top.sv ====
// Testbench for the byte-access timer core
`timescale 1ns/1ps
`default_nettype none
module timer16_counter_byte_access_tb_top;
  import tmc_pkg::*;
  typedef struct packed {logic [3:0] lo; logic [15:0] val;} tmc_row_s;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic ext_tick_pin = 1'h0;
  logic capture_event = 1'h0;
  logic ovf_ack = 1'h0;
  tmc_bus_req_s bus_req;
  logic [7:0] rd_data;
  tmc_view_s view;
  logic timer_tick;
  logic count_top;
  logic count_bottom;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  logic [15:0] v;
  logic [15:0] w;
  tmc_row_s rows [4] = '{'{4'h0, 16'h01ff}, '{4'h2, 16'hbeef}, '{4'h4, 16'h8001}, '{4'h6, 16'h7ffe}};
  tmc_core dut (.clk(clk), .resetn(resetn), .bus_req(bus_req), .rd_data(rd_data),
    .ext_tick_pin(ext_tick_pin), .capture_event(capture_event), .ovf_ack(ovf_ack),
    .view(view), .timer_tick(timer_tick), .count_top(count_top), .count_bottom(count_bottom));
  tmc_cpu cpu (.clk(clk), .bus_req(bus_req), .rd_data(rd_data));
  always #2 clk = ~clk;
  // Generous ceiling, the run needs under 150 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_count++;
      summarize();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'h1;
    #1 chk(view.count, 16'h0000);
    chk({15'h0000, view.overflow_flag}, 16'h0000);
    chk({15'h0000, count_bottom}, 16'h0001);
    foreach (rows[i]) begin
      cpu.wr16(rows[i].lo, rows[i].val);
      cpu.rd16(rows[i].lo, v);
      chk(v, rows[i].val);
    end
    // One high byte shared by two low writes
    cpu.wr8(4'h3, 8'h5a);
    cpu.wr8(4'h2, 8'h11);
    cpu.wr8(4'h4, 8'h22);
    #1 chk(view.cmp_a, 16'h5a11);
    chk(view.cmp_b, 16'h5a22);
    cpu.rd8(4'h0, w[7:0]);
    cpu.rd8(4'h3, w[15:8]);
    chk(w, 16'h5aff);
    cpu.rd8(4'h1, w[7:0]);
    chk({8'h00, w[7:0]}, 16'h0001);
    cpu.rd8(4'hf, w[7:0]);
    chk({8'h00, w[7:0]}, 16'h0000);
    // Mode 5 has a fixed 8-bit top
    cpu.wr8(4'h8, 8'h01);
    cpu.wr8(4'h9, 8'h08);
    cpu.wr16(4'h0, 16'h00ff);
    #1 chk({15'h0000, count_top}, 16'h0001);
    cpu.wr8(4'h8, 8'h00);
    cpu.wr8(4'h9, 8'h00);
    cpu.wr16(4'h0, 16'hffff);
    #1 chk({15'h0000, count_top}, 16'h0001);
    cpu.wr8(4'h9, 8'h01);
    cpu.wr8(4'h9, 8'h00);
    #1 chk({15'h0000, view.overflow_flag}, 16'h0001);
    cpu.rd16(4'h0, v);
    cpu.rd16(4'h0, w);
    chk(v, 16'h0001);
    chk(w, 16'h0001);
    @(posedge clk) ovf_ack <= 1'h1;
    @(posedge clk) ovf_ack <= 1'h0;
    #1 chk({15'h0000, view.overflow_flag}, 16'h0000);
    // Write lands on a cycle that also ticks
    cpu.wr8(4'h9, 8'h01);
    cpu.wr16(4'h0, 16'h1000);
    cpu.wr8(4'h9, 8'h00);
    #1 chk(view.count, 16'h1002);
    // Overflow and acknowledge on one edge: the set wins
    cpu.wr16(4'h0, 16'hffff);
    cpu.wr8(4'h9, 8'h01);
    ovf_ack <= 1'h1;
    @(posedge clk) ovf_ack <= 1'h0;
    cpu.wr8(4'h9, 8'h00);
    #1 chk(view.count, 16'h0002);
    chk({15'h0000, view.overflow_flag}, 16'h0001);
    cpu.rd8(4'ha, w[7:0]);
    chk({8'h00, w[7:0]}, 16'h0001);
    cpu.wr8(4'ha, 8'h01);
    #1 chk({15'h0000, view.overflow_flag}, 16'h0000);
    @(posedge clk) capture_event <= 1'h1;
    @(posedge clk) capture_event <= 1'h0;
    cpu.rd16(4'h6, v);
    chk(v, 16'h0002);
    // Rising edge of the tick pin, then the divide-by-8 tap
    cpu.wr8(4'h9, 8'h07);
    @(posedge clk) ext_tick_pin <= 1'h1;
    #1 chk({15'h0000, timer_tick}, 16'h0001);
    @(posedge clk) ext_tick_pin <= 1'h0;
    cpu.wr8(4'h9, 8'h00);
    #1 chk(view.count, 16'h0003);
    cpu.wr8(4'h9, 8'h02);
    repeat (16) @(posedge clk);
    cpu.wr8(4'h9, 8'h00);
    #1 chk(view.count, 16'h0005);
    // Compare A as top in the clear-on-top mode
    cpu.wr8(4'h9, 8'h08);
    cpu.wr16(4'h0, 16'h5a11);
    #1 chk({15'h0000, count_top}, 16'h0001);
    cpu.wr8(4'h9, 8'h09);
    cpu.wr8(4'h9, 8'h08);
    #1 chk(view.count, 16'h0001);
    // Dual slope with the 8-bit top turns down
    cpu.wr8(4'h8, 8'h01);
    cpu.wr16(4'h0, 16'h00fe);
    cpu.wr8(4'h9, 8'h01);
    cpu.wr8(4'h9, 8'h00);
    #1 chk(view.count, 16'h00fe);
    chk({15'h0000, view.count_down}, 16'h0001);
    chk({12'h000, view.wave_mode}, 16'h0001);
    // Non-zero holding byte so the reset check means something
    cpu.wr8(4'h5, 8'h3c);
    @(posedge clk) resetn <= 1'h0;
    #1 chk(view.count, 16'h0000);
    @(posedge clk) resetn <= 1'h1;
    cpu.rd8(4'h1, w[7:0]);
    chk({8'h00, w[7:0]}, 16'h0000);
    summarize();
  end
endmodule // timer16_counter_byte_access_tb_top
`default_nettype wire
